// [src/pcg_map.svh]
// register addresses, field positions and reset values of the clock gating block
// assumes a 16-bit register address space and 16-bit data
`ifndef PCG_MAP_SVH
`define PCG_MAP_SVH

`define PCG_ADDR_ONE        16'h1c02
`define PCG_ADDR_TWO        16'h1c03

`define PCG_ONE_RESET       16'h0000
`define PCG_TWO_RESET       16'h0000
`define PCG_ONE_RW_MASK     16'h005f
`define PCG_TWO_RW_MASK     16'h007f
`define PCG_ZERO_WORD       16'h0000

// fields of the first gating register
`define PCG_ONE_TWOWIRE     6
`define PCG_ONE_KEEP_ONE    5
`define PCG_ONE_CARD0       4
`define PCG_ONE_DMA0        3
`define PCG_ONE_SERIAL      2
`define PCG_ONE_SPI         1
`define PCG_ONE_AUDIO3      0

// fields of the second gating register
`define PCG_TWO_ANALOG      6
`define PCG_TWO_DMA3        5
`define PCG_TWO_DMA2        4
`define PCG_TWO_DMA1        3
`define PCG_TWO_USB         2
`define PCG_TWO_CONVERTER   1
`define PCG_TWO_DISPLAY     0

// positions in the gated clock vector
`define PCG_G_AUDIO3        0
`define PCG_G_SPI           1
`define PCG_G_SERIAL        2
`define PCG_G_DMA0          3
`define PCG_G_CARD0         4
`define PCG_G_TWOWIRE       5
`define PCG_G_DISPLAY       6
`define PCG_G_CONVERTER     7
`define PCG_G_USB           8
`define PCG_G_DMA1          9
`define PCG_G_DMA2          10
`define PCG_G_DMA3          11
`define PCG_G_ANALOG        12
`define PCG_NUM_GATES       13

`endif

// [src/pcg_pkg.sv]
// types shared by the clock gating block
// assumes pcg_map.svh for the sizes
`include "pcg_map.svh"

package pcg_pkg;
  typedef logic [15:0]                  pcg_word_t;
  typedef logic [`PCG_NUM_GATES-1:0]    pcg_gate_vec_t;
endpackage

// [src/pcg_clock_gate.sv]
// one glitch-free clock gate cell
// assumes the gated clock is the system clock itself
module pcg_clock_gate (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic stop,
  output logic      running,
  output logic      gated_clock
);
  // enable moves only while clock is low, so no pulse is ever cut short
  always_ff @(negedge clock) begin
    if (!reset_n) begin
      running <= 1'b1;
    end else begin
      running <= ~stop;
    end
  end

  assign gated_clock = clock & running;
endmodule // pcg_clock_gate

// [src/pcg_top.sv]
// peripheral clock gating: two gating registers and thirteen gated clocks
// assumes a plain register port on the system clock; peripherals take gated_clock
//
// Contract
// - bit 6 of register one passes twowire clock at 0, stops it at 1
// - bit 4 of register one gates memory-card controller 0 clock
// - bit 3 of register one gates dma controller 0 clock
// - bit 2 of register one gates the serial port clock
// - bit 1 of register one gates the spi controller clock
// - bit 0 of register one gates audio port 3 clock
// - register two bits 6..0 gate analog, dma3..1, usb, converter, display; rest 0
// - while converter gate is 0 the analog register clock keeps running
`include "pcg_map.svh"

module pcg_top
  import pcg_pkg::*;
(
  input  wire logic     clock,
  input  wire logic     reset_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic     reg_write,
  input  wire logic     reg_read,
  output pcg_word_t     reg_rdata_q,
  output pcg_gate_vec_t gated_clock,
  output pcg_gate_vec_t clock_running
);

  pcg_word_t     gate_one_q;
  pcg_word_t     gate_two_q;
  pcg_word_t     rdata_d;
  pcg_gate_vec_t stop_req;

  // bit 5 is not stored: software must write it as 1, yet it reads 0
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gate_one_q <= `PCG_ONE_RESET;
    end else if (reg_write && reg_addr == `PCG_ADDR_ONE) begin
      gate_one_q <= reg_wdata & `PCG_ONE_RW_MASK;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      gate_two_q <= `PCG_TWO_RESET;
    end else if (reg_write && reg_addr == `PCG_ADDR_TWO) begin
      gate_two_q <= reg_wdata & `PCG_TWO_RW_MASK;
    end
  end

  // unmapped addresses read as zero
  always_comb begin
    rdata_d = `PCG_ZERO_WORD;
    if (reg_addr == `PCG_ADDR_ONE) begin
      rdata_d = gate_one_q;
    end else if (reg_addr == `PCG_ADDR_TWO) begin
      rdata_d = gate_two_q;
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      reg_rdata_q <= `PCG_ZERO_WORD;
    end else if (reg_read) begin
      reg_rdata_q <= rdata_d;
    end else begin
      reg_rdata_q <= `PCG_ZERO_WORD;
    end
  end

  // stop permission for serial and usb clocks is software's duty; no interlock here
  always_comb begin
    stop_req                   = '0;
    stop_req[`PCG_G_AUDIO3]    = gate_one_q[`PCG_ONE_AUDIO3];
    stop_req[`PCG_G_SPI]       = gate_one_q[`PCG_ONE_SPI];
    stop_req[`PCG_G_SERIAL]    = gate_one_q[`PCG_ONE_SERIAL];
    stop_req[`PCG_G_DMA0]      = gate_one_q[`PCG_ONE_DMA0];
    stop_req[`PCG_G_CARD0]     = gate_one_q[`PCG_ONE_CARD0];
    stop_req[`PCG_G_TWOWIRE]   = gate_one_q[`PCG_ONE_TWOWIRE];
    stop_req[`PCG_G_DISPLAY]   = gate_two_q[`PCG_TWO_DISPLAY];
    stop_req[`PCG_G_CONVERTER] = gate_two_q[`PCG_TWO_CONVERTER];
    stop_req[`PCG_G_USB]       = gate_two_q[`PCG_TWO_USB];
    stop_req[`PCG_G_DMA1]      = gate_two_q[`PCG_TWO_DMA1];
    stop_req[`PCG_G_DMA2]      = gate_two_q[`PCG_TWO_DMA2];
    stop_req[`PCG_G_DMA3]      = gate_two_q[`PCG_TWO_DMA3];
    // a running converter needs the analog registers, so its gate overrides
    stop_req[`PCG_G_ANALOG]    = gate_two_q[`PCG_TWO_ANALOG] & gate_two_q[`PCG_TWO_CONVERTER];
  end

  // gated clocks are combinational by nature; each enable is a flop on the falling edge
  genvar gi;
  generate
    for (gi = 0; gi < `PCG_NUM_GATES; gi++) begin : g_gate
      pcg_clock_gate u_gate (
        .clock       (clock),
        .reset_n     (reset_n),
        .stop        (stop_req[gi]),
        .running     (clock_running[gi]),
        .gated_clock (gated_clock[gi])
      );
    end
  endgenerate

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence write_one_s;
    reg_write && reg_addr == `PCG_ADDR_ONE;
  endsequence

  sequence write_two_s;
    reg_write && reg_addr == `PCG_ADDR_TWO;
  endsequence

  sequence read_one_s;
    reg_read && reg_addr == `PCG_ADDR_ONE;
  endsequence

  sequence read_two_s;
    reg_read && reg_addr == `PCG_ADDR_TWO;
  endsequence

  sequence read_other_s;
    reg_read && reg_addr != `PCG_ADDR_ONE && reg_addr != `PCG_ADDR_TWO;
  endsequence

  chk_twowire_gate_follow: assert property (
    write_one_s |=> clock_running[`PCG_G_TWOWIRE] == !$past(reg_wdata[`PCG_ONE_TWOWIRE]))
    else $error("twowire clock does not follow its gate bit");

  chk_card0_gate_follow: assert property (
    write_one_s |=> clock_running[`PCG_G_CARD0] == !$past(reg_wdata[`PCG_ONE_CARD0]))
    else $error("card0 clock does not follow its gate bit");

  chk_dma0_gate_follow: assert property (
    write_one_s |=> clock_running[`PCG_G_DMA0] == !$past(reg_wdata[`PCG_ONE_DMA0]))
    else $error("dma0 clock does not follow its gate bit");

  chk_serial_gate_follow: assert property (
    write_one_s |=> clock_running[`PCG_G_SERIAL] == !$past(reg_wdata[`PCG_ONE_SERIAL]))
    else $error("serial port clock does not follow its gate bit");

  chk_spi_gate_follow: assert property (
    write_one_s |=> clock_running[`PCG_G_SPI] == !$past(reg_wdata[`PCG_ONE_SPI]))
    else $error("spi clock does not follow its gate bit");

  chk_audio3_gate_follow: assert property (
    write_one_s |=> clock_running[`PCG_G_AUDIO3] == !$past(reg_wdata[`PCG_ONE_AUDIO3]))
    else $error("audio port 3 clock does not follow its gate bit");

  chk_two_readback: assert property (
    write_two_s ##1 read_two_s
      |=> reg_rdata_q == ($past(reg_wdata, 2) & `PCG_TWO_RW_MASK))
    else $error("register two read back wrong or upper bits not zero");

  chk_one_reserved_zero: assert property (
    reg_read |=> reg_rdata_q[`PCG_ONE_KEEP_ONE] == 1'b0 || $past(reg_addr) != `PCG_ADDR_ONE)
    else $error("reserved bit of register one reads nonzero");

  chk_usb_gate_follow: assert property (
    write_two_s |=> clock_running[`PCG_G_USB] == !$past(reg_wdata[`PCG_TWO_USB]))
    else $error("usb clock does not follow its gate bit");

  chk_display_gate_follow: assert property (
    write_two_s |=> clock_running[`PCG_G_DISPLAY] == !$past(reg_wdata[`PCG_TWO_DISPLAY]))
    else $error("display clock does not follow its gate bit");

  chk_converter_gate_follow: assert property (
    write_two_s |=> clock_running[`PCG_G_CONVERTER] == !$past(reg_wdata[`PCG_TWO_CONVERTER]))
    else $error("converter clock does not follow its gate bit");

  chk_dma1_gate_follow: assert property (
    write_two_s |=> clock_running[`PCG_G_DMA1] == !$past(reg_wdata[`PCG_TWO_DMA1]))
    else $error("dma1 clock does not follow its gate bit");

  chk_dma2_gate_follow: assert property (
    write_two_s |=> clock_running[`PCG_G_DMA2] == !$past(reg_wdata[`PCG_TWO_DMA2]))
    else $error("dma2 clock does not follow its gate bit");

  chk_dma3_gate_follow: assert property (
    write_two_s |=> clock_running[`PCG_G_DMA3] == !$past(reg_wdata[`PCG_TWO_DMA3]))
    else $error("dma3 clock does not follow its gate bit");

  // enable and converter bit are compared at one edge: the enable lags the bit by half a cycle
  chk_analog_kept_on: assert property (
    !gate_two_q[`PCG_TWO_CONVERTER] |-> clock_running[`PCG_G_ANALOG])
    else $error("analog register clock stopped while converter gate is 0");

  chk_analog_stop_both: assert property (
    write_two_s ##0 (reg_wdata[`PCG_TWO_ANALOG] && reg_wdata[`PCG_TWO_CONVERTER])
      |=> !clock_running[`PCG_G_ANALOG])
    else $error("analog register clock runs with both gate bits set");

  chk_one_readback: assert property (
    write_one_s ##1 read_one_s
      |=> reg_rdata_q == ($past(reg_wdata, 2) & `PCG_ONE_RW_MASK))
    else $error("register one read back wrong or reserved bits not zero");

  chk_read_one_value: assert property (
    read_one_s |=> reg_rdata_q == $past(gate_one_q))
    else $error("register one read data differ from stored value");

  chk_read_two_value: assert property (
    read_two_s |=> reg_rdata_q == $past(gate_two_q))
    else $error("register two read data differ from stored value");

  chk_one_upper_zero: assert property (
    read_one_s |=> (reg_rdata_q & ~`PCG_ONE_RW_MASK) == `PCG_ZERO_WORD)
    else $error("unused bits of register one read nonzero");

  chk_two_upper_zero: assert property (
    read_two_s |=> (reg_rdata_q & ~`PCG_TWO_RW_MASK) == `PCG_ZERO_WORD)
    else $error("unused bits of register two read nonzero");

  chk_one_store_masked: assert property (
    (gate_one_q & ~`PCG_ONE_RW_MASK) == `PCG_ZERO_WORD)
    else $error("register one holds a bit outside its gate fields");

  chk_two_store_masked: assert property (
    (gate_two_q & ~`PCG_TWO_RW_MASK) == `PCG_ZERO_WORD)
    else $error("register two holds a bit outside its gate fields");

  chk_one_holds_value: assert property (
    !(reg_write && reg_addr == `PCG_ADDR_ONE) |=> $stable(gate_one_q))
    else $error("register one changed without a write to it");

  chk_two_holds_value: assert property (
    !(reg_write && reg_addr == `PCG_ADDR_TWO) |=> $stable(gate_two_q))
    else $error("register two changed without a write to it");

  chk_rdata_idle_zero: assert property (
    !reg_read |=> reg_rdata_q == `PCG_ZERO_WORD)
    else $error("read data not zero outside the read answer cycle");

  chk_unmapped_read_zero: assert property (
    read_other_s |=> reg_rdata_q == `PCG_ZERO_WORD)
    else $error("unmapped address read nonzero");

  // reset checks must run while reset is low, so they opt out of the default disable
  chk_reset_values: assert property (
    @(posedge clock) disable iff (1'b0)
    !reset_n |=> gate_one_q == `PCG_ONE_RESET && gate_two_q == `PCG_TWO_RESET &&
      reg_rdata_q == `PCG_ZERO_WORD)
    else $error("registers not at reset value after reset");

  chk_reset_all_running: assert property (
    @(posedge clock) disable iff (1'b0)
    !reset_n ##1 !reset_n |-> clock_running == '1)
    else $error("a clock is stopped during reset");

  chk_enable_matches_req: assert property (
    clock_running == ~stop_req)
    else $error("clock enable does not match its gate request");

  chk_enable_only_on_req: assert property (
    $changed(clock_running) |-> $changed(stop_req))
    else $error("clock enable changed without a gate request");

  chk_gated_low_phase: assert property (
    gated_clock == '0)
    else $error("gated clock high while the system clock is low");

  chk_gated_high_phase: assert property (
    @(negedge clock) gated_clock == clock_running)
    else $error("gated clock high phase differs from its enable");

endmodule // pcg_top

// [bench/test_pcg_top.sv]
// self-checking bench for the peripheral clock gating block
// assumes pcg_map.svh and pcg_pkg are compiled first; bench drives all ports itself
`include "pcg_map.svh"

module test_pcg_top
  import pcg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct {
    pcg_word_t     one;
    pcg_word_t     two;
    pcg_word_t     rd_one;
    pcg_word_t     rd_two;
    pcg_gate_vec_t run;
  } pcg_row_t;

  logic          clock;
  logic          reset_n;
  logic [15:0]   reg_addr;
  logic [15:0]   reg_wdata;
  logic          reg_write;
  logic          reg_read;
  pcg_word_t     reg_rdata_q;
  pcg_gate_vec_t gated_clock;
  pcg_gate_vec_t clock_running;
  int            n_mismatch;
  int            total_checks;
  // analog stays running unless the converter gate is set too
  pcg_row_t      rows [5] = '{
    '{16'h0020, 16'h0000, 16'h0000, 16'h0000, 13'h1fff},
    '{16'hffff, 16'hffff, 16'h005f, 16'h007f, 13'h0000},
    '{16'h0061, 16'h0040, 16'h0041, 16'h0040, 13'h1fde},
    '{16'h0034, 16'h0003, 16'h0014, 16'h0003, 13'h1f2b},
    '{16'h002a, 16'h003c, 16'h000a, 16'h003c, 13'h10f5}};

  pcg_top i_pcg_top (
    .clock         (clock),
    .reset_n       (reset_n),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_write     (reg_write),
    .reg_read      (reg_read),
    .reg_rdata_q   (reg_rdata_q),
    .gated_clock   (gated_clock),
    .clock_running (clock_running)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // wr, rd and gates start and end on a rising edge; wr leaves the strobe up so writes chain
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    reg_read  <= 1'b0;
    @(posedge clock);
  endtask

  // read data stand only in the cycle right after the strobe
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    reg_addr  <= a;
    reg_write <= 1'b0;
    reg_read  <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    @(negedge clock);
    chk("reg_rdata_q", exp, reg_rdata_q);
    @(posedge clock);
  endtask

  // enable flips on the falling edge, so the next high phase shows it
  task automatic gates(input pcg_gate_vec_t exp);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    @(posedge clock);
    #10 chk("clock_running", 16'(exp), 16'(clock_running));
    chk("gated_high", 16'(exp), 16'(gated_clock));
    @(negedge clock);
    #10 chk("gated_low", 16'h0000, 16'(gated_clock));
    @(posedge clock);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    #1000000 n_mismatch++;
    conclude();
  end

  initial begin
    reset_n = 1'b0; reg_addr = 16'h0000; reg_wdata = 16'h0000;
    reg_write = 1'b0; reg_read = 1'b0; n_mismatch = 0; total_checks = 0;
    repeat (2) @(posedge clock);
    gates(13'h1fff);
    reset_n <= 1'b1;
    $display("test reset done");
    // stop permission for serial and usb clocks is taken as already granted
    foreach (rows[i]) begin
      wr(`PCG_ADDR_ONE, rows[i].one);
      wr(`PCG_ADDR_TWO, rows[i].two);
      gates(rows[i].run);
      rd(`PCG_ADDR_ONE, rows[i].rd_one);
      rd(`PCG_ADDR_TWO, rows[i].rd_two);
      $display("test row %0d done", i);
    end
    wr(16'h1c04, 16'hffff);
    rd(16'h1c04, 16'h0000);
    @(negedge clock);
    chk("rdata_after", 16'h0000, reg_rdata_q);
    @(posedge clock);
    rd(`PCG_ADDR_TWO, 16'h003c);
    rd(`PCG_ADDR_ONE, 16'h000a);
    $display("test unmapped done");
    wr(`PCG_ADDR_TWO, 16'h0042);
    rd(`PCG_ADDR_TWO, 16'h0042);
    wr(`PCG_ADDR_ONE, 16'h0024);
    rd(`PCG_ADDR_ONE, 16'h0004);
    gates(13'h0f7b);
    $display("test back to back done");
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    gates(13'h1fff);
    rd(`PCG_ADDR_ONE, 16'h0000);
    rd(`PCG_ADDR_TWO, 16'h0000);
    $display("test second reset done");
    conclude();
  end
endmodule // test_pcg_top
